//--- src/cbc_top.sv
// core bus control signalling: memory cycle enables, coprocessor handshake,
// interrupt intake, scan high-z select and inverted mode outputs
// assumes sys_clk stands for the memory clock; a high on cycle_wait_n lets a cycle end
//
// How it works
// - cycle advances only when wait input high
// - coprocessor instruction drives copro_instr_n low, waits
// - response inputs pick next coprocessor action
// - write enable low whole write cycle
// - data_drive_en combines enable input with it
// - comms enable low whole comms transfer cycle
// - not_executed high when condition check fails
// - fast interrupt taken when low and enabled
// - normal interrupt lower priority, own enable
// - sync select picks sync or async intake
// - select low synchronises, high bypasses
// - high-z select low during HIGHZ instruction
// - mode output is inverse of mode bits
`timescale 1ns/1ps
`default_nettype none
module cbc_top (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     reset_n,
  // memory cycle control pin
  input  wire logic                     cycle_wait_n,
  // core-side status for the cycle being started
  input  wire cbc_pkg::cbc_core_stat_t  core_stat,
  input  wire logic                     copro_start,
  input  wire logic                     fiq_enable,
  input  wire logic                     irq_enable,
  // coprocessor pins
  input  wire logic                     copro_absent,
  input  wire logic                     copro_busy,
  output logic                          copro_instr_n,
  // data bus enables
  input  wire logic                     bus_enable_in_n,
  output logic                          write_enable_out_n,
  output logic                          comms_enable_out_n,
  output logic                          data_drive_en,
  // execute status and mode
  output logic                          not_executed,
  output logic [cbc_pkg::MODE_W-1:0]    proc_mode_inv,
  // interrupt pins and results
  input  wire logic                     fast_irq_req_n,
  input  wire logic                     normal_irq_req_n,
  input  wire logic                     irq_sync_select,
  output logic                          take_fiq,
  output logic                          take_irq,
  // coprocessor result to the core
  output cbc_pkg::cbc_cp_result_t       copro_result,
  // scan chain
  output logic                          scan_hiz_select_n
);

  // external pins cross into sys_clk before use
  logic wait_m_q, wait_s_q;
  logic cpa_m_q, cpa_s_q, cpb_m_q, cpb_s_q;
  logic enin_m_q, enin_s_q;
  // sync select is a pin too; reset picks the safe synchronising path
  logic isel_m_q, isel_s_q;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wait_m_q <= 1'b1;
      wait_s_q <= 1'b1;
      cpa_m_q  <= 1'b1;
      cpa_s_q  <= 1'b1;
      cpb_m_q  <= 1'b1;
      cpb_s_q  <= 1'b1;
      enin_m_q <= 1'b1;
      enin_s_q <= 1'b1;
      isel_m_q <= 1'b0;
      isel_s_q <= 1'b0;
    end else begin
      wait_m_q <= cycle_wait_n;
      wait_s_q <= wait_m_q;
      cpa_m_q  <= copro_absent;
      cpa_s_q  <= cpa_m_q;
      cpb_m_q  <= copro_busy;
      cpb_s_q  <= cpb_m_q;
      enin_m_q <= bus_enable_in_n;
      enin_s_q <= enin_m_q;
      isel_m_q <= irq_sync_select;
      isel_s_q <= isel_m_q;
    end
  end

  // cycle boundary: a low wait holds everything but the scan high-z select, data_drive_en and copro_result, a stretched clock just gives no edges
  wire cycle_adv = wait_s_q;

  // coprocessor handshake state
  typedef enum logic [1:0] {CBC_CP_IDLE, CBC_CP_WAIT} cbc_cp_state_t;
  cbc_cp_state_t cp_state_q, cp_state_d;
  cbc_pkg::cbc_cp_result_t cp_result_d;

  wire cbc_pkg::cbc_copro_resp_t resp = '{absent: cpa_s_q, busy: cpb_s_q};

  // next action decided by the response combination
  always_comb begin
    cp_state_d  = cp_state_q;
    cp_result_d = cbc_pkg::CBC_CP_NONE;
    case (cp_state_q)
      CBC_CP_IDLE: begin
        if (cycle_adv && copro_start) begin
          cp_state_d = CBC_CP_WAIT;
        end
      end
      CBC_CP_WAIT: begin
        if (cycle_adv) begin
          if (resp.absent) begin
            cp_state_d  = CBC_CP_IDLE;
            cp_result_d = cbc_pkg::CBC_CP_UNDEF;
          end else if (!resp.busy) begin
            cp_state_d  = CBC_CP_IDLE;
            cp_result_d = cbc_pkg::CBC_CP_DONE;
          end
        end
      end
      default: cp_state_d = CBC_CP_IDLE;
    endcase
  end

  // interrupt intake, synchronised unless select is high
  logic fiq_n_in, irq_n_in;
  cbc_irq_sync u_fiq_sync (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .bypass    (isel_s_q),
    .req_n     (fast_irq_req_n),
    .req_n_out (fiq_n_in)
  );
  cbc_irq_sync u_irq_sync (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .bypass    (isel_s_q),
    .req_n     (normal_irq_req_n),
    .req_n_out (irq_n_in)
  );

  // level sensitive; an enabled fast request masks the normal one
  wire fiq_raw = !fiq_n_in && fiq_enable;
  wire irq_raw = !irq_n_in && irq_enable && !fiq_raw;

  // registered cycle outputs update only at a cycle boundary; the scan high-z select and copro_result update on every edge
  logic wen_q, cen_q, not_executed_q, hiz_q, cpi_q, fiq_q, irq_q;
  logic [cbc_pkg::MODE_W-1:0] mode_q;
  cbc_pkg::cbc_cp_result_t cp_result_q;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cp_state_q  <= CBC_CP_IDLE;
      cp_result_q <= cbc_pkg::CBC_CP_NONE;
      cpi_q       <= cbc_pkg::INACTIVE_N;
      wen_q       <= cbc_pkg::INACTIVE_N;
      cen_q       <= cbc_pkg::INACTIVE_N;
      not_executed_q     <= 1'b0;
      hiz_q       <= cbc_pkg::INACTIVE_N;
      mode_q      <= ~cbc_pkg::MODE_RESET;
      fiq_q       <= 1'b0;
      irq_q       <= 1'b0;
    end else begin
      cp_state_q  <= cp_state_d;
      cp_result_q <= cp_result_d;
      cpi_q       <= ~(cp_state_d == CBC_CP_WAIT);
      hiz_q       <= ~core_stat.highz_instr;
      if (cycle_adv) begin
        wen_q   <= ~core_stat.write_cycle;
        cen_q   <= ~core_stat.comms_cycle;
        not_executed_q <= core_stat.cond_fail;
        mode_q  <= ~core_stat.mode;
        fiq_q   <= fiq_raw;
        irq_q   <= irq_raw;
      end
    end
  end

  assign copro_instr_n      = cpi_q;
  assign copro_result       = cp_result_q;
  assign write_enable_out_n = wen_q;
  assign comms_enable_out_n = cen_q;
  // drive data only when writing and the system grants the bus
  assign data_drive_en      = !wen_q && !enin_s_q;
  assign not_executed       = not_executed_q;
  assign proc_mode_inv      = mode_q;
  assign scan_hiz_select_n  = hiz_q;
  assign take_fiq           = fiq_q;
  assign take_irq           = irq_q;

  // write enable follows its cause one cycle after an advancing edge
  property p_wen;
    @(posedge sys_clk) disable iff (!reset_n)
      cycle_adv |=> (write_enable_out_n == !$past(core_stat.write_cycle));
  endproperty
  a_wen: assert property (p_wen) else $error("write enable wrong");

  property p_wen_hold;
    @(posedge sys_clk) disable iff (!reset_n)
      !cycle_adv |=> $stable(write_enable_out_n);
  endproperty
  a_wen_hold: assert property (p_wen_hold) else $error("write enable moved in wait");

  property p_cen;
    @(posedge sys_clk) disable iff (!reset_n)
      (cycle_adv && !core_stat.comms_cycle) |=> comms_enable_out_n;
  endproperty
  a_cen: assert property (p_cen) else $error("comms enable low outside cycle");

  property p_cen_low;
    @(posedge sys_clk) disable iff (!reset_n)
      (cycle_adv && core_stat.comms_cycle) |=> !comms_enable_out_n;
  endproperty
  a_cen_low: assert property (p_cen_low) else $error("comms enable not low");

  property p_cpi;
    @(posedge sys_clk) disable iff (!reset_n)
      (cp_state_q == CBC_CP_IDLE && cycle_adv && copro_start) |=> !copro_instr_n;
  endproperty
  a_cpi: assert property (p_cpi) else $error("copro instruction not asserted");

  property p_cp_undef;
    @(posedge sys_clk) disable iff (!reset_n)
      (cp_state_q == CBC_CP_WAIT && cycle_adv && cpa_s_q) |=> (copro_result == cbc_pkg::CBC_CP_UNDEF);
  endproperty
  a_cp_undef: assert property (p_cp_undef) else $error("absent coprocessor not reported");

  property p_prio;
    @(posedge sys_clk) disable iff (!reset_n)
      !(take_fiq && take_irq);
  endproperty
  a_prio: assert property (p_prio) else $error("both interrupts taken");

  property p_mode;
    @(posedge sys_clk) disable iff (!reset_n)
      cycle_adv |=> (proc_mode_inv == ~$past(core_stat.mode));
  endproperty
  a_mode: assert property (p_mode) else $error("mode not inverted");

  property p_hiz;
    @(posedge sys_clk) disable iff (!reset_n)
      core_stat.highz_instr |=> !scan_hiz_select_n;
  endproperty
  a_hiz: assert property (p_hiz) else $error("high-z select not low");

  property p_not_executed;
    @(posedge sys_clk) disable iff (!reset_n)
      (cycle_adv && core_stat.cond_fail) |=> not_executed;
  endproperty
  a_not_executed: assert property (p_not_executed) else $error("not executed missing");

  property p_fiq;
    @(posedge sys_clk) disable iff (!reset_n)
      (isel_s_q && !fast_irq_req_n && fiq_enable && cycle_adv) |=> take_fiq;
  endproperty
  a_fiq: assert property (p_fiq) else $error("fast interrupt not taken");

endmodule
`default_nettype wire

//--- src/cbc_pkg.sv
// package for the core bus control signal block
// assumes one system clock; all pins are plain ports
package cbc_pkg;

  // processor mode field width
  localparam int MODE_W = 5;
  // reset value of the internal mode status (supervisor-like default)
  localparam logic [4:0] MODE_RESET = 5'h13;
  // reset level of all active-low enables (inactive)
  localparam logic INACTIVE_N = 1'b1;

  // coprocessor response as seen on the two response inputs
  typedef struct packed {
    logic absent;
    logic busy;
  } cbc_copro_resp_t;

  // one cycle's worth of core-side status
  typedef struct packed {
    logic       write_cycle;
    logic       comms_cycle;
    logic       cond_fail;
    logic       highz_instr;
    logic [4:0] mode;
  } cbc_core_stat_t;

  // coprocessor handshake outcome presented to the core
  typedef enum logic [1:0] {
    CBC_CP_NONE,
    CBC_CP_DONE,
    CBC_CP_UNDEF
  } cbc_cp_result_t;

endpackage

//--- src/cbc_irq_sync.sv
// interrupt request input stage: two-flop synchroniser with bypass
// assumes the request pins may be asynchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module cbc_irq_sync (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // bypass select: high means input is already synchronous
  input  wire logic bypass,
  // raw request pin, active low
  input  wire logic req_n,
  // request as seen by the core, active low
  output logic      req_n_out
);

  logic meta_q;
  logic sync_q;

  // first flop feeds only the second flop
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= req_n;
      sync_q <= meta_q;
    end
  end

  // bypass trades metastability safety for two cycles less latency
  assign req_n_out = bypass ? req_n : sync_q;

endmodule
`default_nettype wire

//--- tb/cbc_copro_model.sv
// coprocessor partner model for the core bus control block
// assumes the response pins are sampled by the block on sys_clk
`timescale 1ns/1ps
`default_nettype none
module cbc_copro_model (
  // clock
  input  wire logic       sys_clk,
  // handshake from the block
  input  wire logic       copro_instr_n,
  // model setup from the bench
  input  wire logic       fitted,
  input  wire logic [3:0] delay,
  // response pins
  output logic            copro_absent,
  output logic            copro_busy
);
  logic [3:0] wait_cnt_q;

  // cycles spent in the current handshake, saturating
  always_ff @(posedge sys_clk) begin
    if (copro_instr_n) wait_cnt_q <= 4'h0;
    else if (wait_cnt_q != 4'hF) wait_cnt_q <= wait_cnt_q + 4'h1;
  end

  // an unfitted slot answers absent at once; busy stays high while idle so a stray sample never completes
  assign copro_absent = !fitted;
  assign copro_busy   = copro_instr_n || (wait_cnt_q < delay);
endmodule
`default_nettype wire

//--- tb/test_core_bus_control_signals.sv
// self-checking bench for the core bus control block
// assumes the design under src/ and the coprocessor model beside this file
`timescale 1ns/1ps
`default_nettype none
module test_core_bus_control_signals;
  logic sys_clk = 1'b0, reset_n = 1'b0, cycle_wait_n = 1'b1, copro_start = 1'b0;
  logic fiq_enable = 1'b0, irq_enable = 1'b0, bus_enable_in_n = 1'b1, fitted = 1'b1;
  logic fast_irq_req_n = 1'b1, normal_irq_req_n = 1'b1, irq_sync_select = 1'b0;
  logic [3:0] delay = 4'h0;
  cbc_pkg::cbc_core_stat_t core_stat = '0, prev;
  logic copro_absent, copro_busy, copro_instr_n, write_enable_out_n, comms_enable_out_n;
  logic data_drive_en, not_executed, take_fiq, take_irq, scan_hiz_select_n;
  logic [4:0] proc_mode_inv;
  cbc_pkg::cbc_cp_result_t copro_result;
  integer seed = 19, miscompares = 0, total_checks = 0, i, n;

  always #5 sys_clk = ~sys_clk;

  cbc_top dut (.sys_clk(sys_clk), .reset_n(reset_n), .cycle_wait_n(cycle_wait_n), .core_stat(core_stat),
    .copro_start(copro_start), .fiq_enable(fiq_enable), .irq_enable(irq_enable), .copro_absent(copro_absent),
    .copro_busy(copro_busy), .copro_instr_n(copro_instr_n), .bus_enable_in_n(bus_enable_in_n),
    .write_enable_out_n(write_enable_out_n), .comms_enable_out_n(comms_enable_out_n),
    .data_drive_en(data_drive_en), .not_executed(not_executed), .proc_mode_inv(proc_mode_inv),
    .fast_irq_req_n(fast_irq_req_n), .normal_irq_req_n(normal_irq_req_n), .irq_sync_select(irq_sync_select),
    .take_fiq(take_fiq), .take_irq(take_irq), .copro_result(copro_result), .scan_hiz_select_n(scan_hiz_select_n));

  cbc_copro_model partner (.sys_clk(sys_clk), .copro_instr_n(copro_instr_n), .fitted(fitted), .delay(delay),
    .copro_absent(copro_absent), .copro_busy(copro_busy));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("mismatches %0d of %0d checks", miscompares, total_checks);
    if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // per-cycle outputs against the vector sampled one edge earlier
  task automatic check_cycle(input cbc_pkg::cbc_core_stat_t s);
    check(write_enable_out_n, !s.write_cycle);
    check(comms_enable_out_n, !s.comms_cycle);
    check(not_executed, s.cond_fail);
    check(proc_mode_inv, {3'h0, ~s.mode});
    check(scan_hiz_select_n, !s.highz_instr);
  endtask

  // a hang would otherwise hide every later scenario
  initial begin
    #200000;
    miscompares = miscompares + 1;
    stop_test();
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    check(proc_mode_inv, {3'h0, ~cbc_pkg::MODE_RESET});
    check({copro_instr_n, write_enable_out_n, comms_enable_out_n, scan_hiz_select_n}, 8'h0F);
    check({not_executed, take_fiq, take_irq, data_drive_en}, 8'h00);
    check(copro_result, cbc_pkg::CBC_CP_NONE);
    @(posedge sys_clk) reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // random cycles with the wait pin high: one cycle advances per edge
    prev = core_stat;
    for (i = 0; i < 200; i = i + 1) begin
      @(posedge sys_clk) core_stat <= 9'($random(seed));
      @(negedge sys_clk);
      check_cycle(prev);
      prev = core_stat;
    end
    // stretched cycle: outputs freeze while the wait pin is low, scan select keeps tracking
    @(posedge sys_clk) core_stat <= 9'h100;
    repeat (3) @(posedge sys_clk);
    cycle_wait_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    core_stat <= 9'h020;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    check(write_enable_out_n, 8'h00);
    check(scan_hiz_select_n, 8'h00);
    @(posedge sys_clk) cycle_wait_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    check(write_enable_out_n, 8'h01);
    // sources hold each request level steady until it has been answered
    for (i = 0; i < 64; i = i + 1) begin
      @(posedge sys_clk);
      fast_irq_req_n <= i[0];
      normal_irq_req_n <= i[1];
      fiq_enable <= i[2];
      irq_enable <= i[3];
      irq_sync_select <= i[4];
      bus_enable_in_n <= i[5];
      core_stat <= {i[2], 8'h00};
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk);
      check(take_fiq, i[2] & !i[0]);
      check(take_irq, i[3] & !i[1] & !(i[2] & !i[0]));
      check(data_drive_en, i[2] & !i[5]);
    end
    // coprocessor handshake: fitted or absent, prompt or slow
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge sys_clk);
      fitted <= i[0];
      delay <= i[1] ? 4'h6 : 4'h0;
      @(posedge sys_clk) copro_start <= 1'b1;
      @(posedge sys_clk) copro_start <= 1'b0;
      @(negedge sys_clk);
      check(copro_instr_n, 8'h00);
      n = 0;
      while (copro_result === cbc_pkg::CBC_CP_NONE && n < 40) begin
        @(negedge sys_clk);
        n = n + 1;
      end
      check(copro_result, i[0] ? cbc_pkg::CBC_CP_DONE : cbc_pkg::CBC_CP_UNDEF);
      check(copro_instr_n, 8'h01);
      check(n >= (i[0] && i[1] ? 6 : 0), 8'h01);
      repeat (3) @(posedge sys_clk);
    end
    stop_test();
  end
endmodule
`default_nettype wire
